//--- event_delay.v
// one-shot delay: fires one cycle, count cycles after a trigger
module event_delay
#(
  parameter CW = 12
)
(
  input  wire          SYS_CLK,
  input  wire          RST_N,
  input  wire          trig,
  input  wire [CW-1:0] count,
  output reg           fire
);

  reg [CW-1:0] remain;
  reg          running;

  // a new trigger restarts the delay
  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      remain  <= {CW{1'b0}};
      running <= 1'b0;
      fire    <= 1'b0;
    end
    else if (trig)
    begin
      fire    <= (count <= {{(CW-1){1'b0}}, 1'b1});
      running <= (count > {{(CW-1){1'b0}}, 1'b1});
      remain  <= count - {{(CW-1){1'b0}}, 1'b1};
    end
    else if (running)
    begin
      fire    <= (remain == {{(CW-1){1'b0}}, 1'b1});
      running <= (remain != {{(CW-1){1'b0}}, 1'b1});
      remain  <= remain - {{(CW-1){1'b0}}, 1'b1};
    end
    else
    begin
      fire <= 1'b0;
    end
  end

endmodule

//--- mac_model.sv
// mac transmit side model driving the mii transmit pins
module mac_model
(
  input  wire        TX_CLK,
  output logic       TX_EN,
  output logic       TX_ER,
  output logic [3:0] TXD
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    TX_EN = 1'b0;
    TX_ER = 1'b0;
    TXD   = 4'h0;
  end
  // pins change half a period away from the sampling rise
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge TX_CLK);
      TX_EN = 1'b1;
      TX_ER = (i == 4);
      TXD   = i[3:0];
    end
    @(negedge TX_CLK);
    TX_EN = 1'b0;
    TX_ER = 1'b0;
    TXD   = ~TXD;
  endtask
endmodule

//--- mii_timing.v
// mii side of a 10/100 transceiver: carrier, collision and data timing
`include "mii_timing_regs.vh"

module mii_timing
#(
  parameter CW     = 12,
  parameter NSLOT  = 2,
  parameter TXDEPTH = 32
)
(
  input  wire       SYS_CLK,
  input  wire       RST_N,
  input  wire [1:0] MEDIUM_MODE,
  input  wire       TX_CLK,
  input  wire       TX_EN,
  input  wire       TX_ER,
  input  wire [3:0] TXD,
  input  wire       LINE_RX_J,
  input  wire       LINE_RX_T,
  input  wire       LINE_RX_ACTIVE,
  input  wire       LINE_RX_VALID,
  input  wire [3:0] LINE_RX_NIBBLE,
  input  wire       LINE_RX_ERR,
  output reg        CRS,
  output reg        COL,
  output reg        RX_DV,
  output reg        RX_ER,
  output reg  [3:0] RXD,
  output reg        LINE_TX_EN,
  output reg  [3:0] LINE_TX_DATA,
  output reg        LINE_TX_ERR
);

  localparam NT        = 10;
  localparam T_CRS_ON  = 0;
  localparam T_DV_ON   = 1;
  localparam T_CRS_OFF = 2;
  localparam T_DV_OFF  = 3;
  localparam T_COL_ON  = 4;
  localparam T_COL_OFF = 5;
  localparam T_TX_ON   = 6;
  localparam T_TX_OFF  = 7;
  localparam T_LTX_ON  = 8;
  localparam T_LTX_OFF = 9;
  localparam AW        = 5;

  // tenths of a bit time to clock cycles, less the path already spent
  function [CW-1:0] to_cyc;
    input [31:0] dbt;
    input        slow;
    input [3:0]  spent;
    reg   [31:0] c;
    begin
      c = (dbt * (slow ? `BIT_NS_SLOW : `BIT_NS_FAST)) / (10 * `CLK_NS);
      if (c > spent + 1)
        c = c - spent;
      else
        c = 32'h1;
      to_cyc = c[CW-1:0];
    end
  endfunction

  wire          ten = (MEDIUM_MODE[1] == 1'b1);
  wire          fx  = (MEDIUM_MODE == `MODE_FX);
  wire [6:0]    pin_s;
  reg           clk_prev;
  reg           act_prev;
  reg           tx_en_smp;
  reg           rx_crs;
  reg           tx_crs;
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [4:0]    tx_mem [0:TXDEPTH-1];
  reg  [NT-1:0] trig;
  reg  [NT*CW-1:0] cnt;
  wire [NT-1:0] fire;
  reg  [NSLOT-1:0] slot_trig;
  wire [NSLOT-1:0] slot_fire;
  reg  [4:0]    slot_data [0:NSLOT-1];
  reg  [0:0]    slot_wr;
  reg  [4:0]    rx_nib;
  integer       k;
  integer       si;
  integer       ti;

  pin_sync #(.WIDTH(7)) u_sync (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .din     ({TX_CLK, TX_EN, TX_ER, TXD}),
    .dout    (pin_s)
  );

  wire       clk_s   = pin_s[6];
  wire       en_s    = pin_s[5];
  wire       er_s    = pin_s[4];
  wire [3:0] txd_s   = pin_s[3:0];
  // transmit pins are taken on the rising edge of the link clock
  wire       tx_rise = clk_s & ~clk_prev;
  wire       tx_start = tx_rise & en_s & ~tx_en_smp;
  wire       tx_end   = tx_rise & ~en_s & tx_en_smp;
  wire       rx_start = ten ? (LINE_RX_ACTIVE & ~act_prev) : LINE_RX_J;
  wire       rx_end   = ten ? (~LINE_RX_ACTIVE & act_prev) : LINE_RX_T;

  // latency set per medium mode
  always @*
  begin
    cnt = {NT*CW{1'b0}};
    case (MEDIUM_MODE)
      `MODE_CU:
      begin
        cnt[T_CRS_ON*CW +: CW]  = to_cyc(`RX_CRS_ON_J, 1'b0, 4'h1);
        cnt[T_DV_ON*CW +: CW]   = to_cyc(`DV_AFTER_CRS_FAST, 1'b0, 4'h0);
        cnt[T_CRS_OFF*CW +: CW] = to_cyc(`RX_CRS_OFF_T_CU, 1'b0, 4'h1);
        cnt[T_DV_OFF*CW +: CW]  = to_cyc(`RX_CRS_OFF_T_CU, 1'b0, 4'h1);
        cnt[T_COL_ON*CW +: CW]  = to_cyc(`COL_ON_J_CU, 1'b0, 4'h1);
        cnt[T_COL_OFF*CW +: CW] = to_cyc(`COL_OFF_T_CU, 1'b0, 4'h1);
        cnt[T_TX_ON*CW +: CW]   = to_cyc(`TX_CRS_ON_CU, 1'b0, 4'h3);
        cnt[T_TX_OFF*CW +: CW]  = to_cyc(`TX_CRS_OFF_CU, 1'b0, 4'h3);
        cnt[T_LTX_ON*CW +: CW]  = to_cyc(`TX_LAT_CU, 1'b0, 4'h3);
        cnt[T_LTX_OFF*CW +: CW] = to_cyc(`TX_LAT_CU, 1'b0, 4'h3);
      end
      `MODE_FX:
      begin
        cnt[T_CRS_ON*CW +: CW]  = to_cyc(`RX_CRS_ON_J, 1'b0, 4'h1);
        cnt[T_DV_ON*CW +: CW]   = to_cyc(`DV_AFTER_CRS_FAST, 1'b0, 4'h0);
        cnt[T_CRS_OFF*CW +: CW] = to_cyc(`RX_CRS_OFF_T_FX, 1'b0, 4'h1);
        cnt[T_DV_OFF*CW +: CW]  = to_cyc(`RX_CRS_OFF_T_FX, 1'b0, 4'h1);
        cnt[T_COL_ON*CW +: CW]  = to_cyc(`COL_ON_J_FX, 1'b0, 4'h1);
        cnt[T_COL_OFF*CW +: CW] = to_cyc(`COL_OFF_T_FX, 1'b0, 4'h1);
        cnt[T_TX_ON*CW +: CW]   = to_cyc(`TX_CRS_ON_FX, 1'b0, 4'h3);
        cnt[T_TX_OFF*CW +: CW]  = to_cyc(`TX_CRS_OFF_FX, 1'b0, 4'h3);
        cnt[T_LTX_ON*CW +: CW]  = to_cyc(`TX_LAT_FX, 1'b0, 4'h3);
        cnt[T_LTX_OFF*CW +: CW] = to_cyc(`TX_LAT_FX, 1'b0, 4'h3);
      end
      default:
      begin
        cnt[T_CRS_ON*CW +: CW]  = to_cyc(`CRS_ON_ACT_TEN, 1'b1, 4'h1);
        cnt[T_DV_ON*CW +: CW]   = to_cyc(`DV_AFTER_CRS_TEN, 1'b1, 4'h0);
        cnt[T_CRS_OFF*CW +: CW] = to_cyc(`DV_OFF_QUIET_TEN + `CRS_AFTER_DV_TEN,
                                         1'b1, 4'h1);
        cnt[T_DV_OFF*CW +: CW]  = to_cyc(`DV_OFF_QUIET_TEN, 1'b1, 4'h1);
        cnt[T_COL_ON*CW +: CW]  = to_cyc(`COL_ON_ACT_TEN, 1'b1, 4'h1);
        cnt[T_COL_OFF*CW +: CW] = to_cyc(`COL_OFF_QUIET_TEN, 1'b1, 4'h1);
        cnt[T_TX_ON*CW +: CW]   = to_cyc(`TX_CRS_ON_TEN, 1'b1, 4'h3);
        cnt[T_TX_OFF*CW +: CW]  = to_cyc(`TX_CRS_OFF_TEN, 1'b1, 4'h3);
        cnt[T_LTX_ON*CW +: CW]  = to_cyc(`TX_LAT_TEN, 1'b1, 4'h3);
        cnt[T_LTX_OFF*CW +: CW] = to_cyc(`TX_LAT_TEN, 1'b1, 4'h3);
      end
    endcase
  end

  always @*
  begin
    trig            = {NT{1'b0}};
    trig[T_CRS_ON]  = rx_start;
    trig[T_COL_ON]  = rx_start;
    trig[T_DV_ON]   = fire[T_CRS_ON];
    trig[T_CRS_OFF] = rx_end;
    trig[T_DV_OFF]  = rx_end;
    trig[T_COL_OFF] = rx_end;
    trig[T_TX_ON]   = tx_start;
    trig[T_LTX_ON]  = tx_start;
    trig[T_TX_OFF]  = tx_end;
    trig[T_LTX_OFF] = tx_end;
  end

  genvar i;
  generate
    for (i = 0; i < NT; i = i + 1)
    begin : g_timer
      event_delay #(.CW(CW)) u_dly (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .trig    (trig[i]),
        .count   (cnt[i*CW +: CW]),
        .fire    (fire[i])
      );
    end
    for (i = 0; i < NSLOT; i = i + 1)
    begin : g_slot
      event_delay #(.CW(CW)) u_rxd (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .trig    (slot_trig[i]),
        .count   (to_cyc(ten ? `RX_LAT_TEN : `RX_LAT_FAST, ten, 4'h1)),
        .fire    (slot_fire[i])
      );
    end
  endgenerate

  // received nibbles take turns in the latency slots
  always @*
  begin
    slot_trig = {NSLOT{1'b0}};
    slot_trig[slot_wr] = LINE_RX_VALID;
    rx_nib = slot_data[0];
    for (k = 0; k < NSLOT; k = k + 1)
      if (slot_fire[k])
        rx_nib = slot_data[k];
  end

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      slot_wr <= 1'b0;
      for (si = 0; si < NSLOT; si = si + 1)
        slot_data[si] <= 5'h00;
    end
    else if (LINE_RX_VALID)
    begin
      slot_data[slot_wr] <= {LINE_RX_ERR, LINE_RX_NIBBLE};
      slot_wr            <= slot_wr + 1'b1;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      clk_prev  <= 1'b0;
      act_prev  <= 1'b0;
      tx_en_smp <= 1'b0;
      rx_crs    <= 1'b0;
      tx_crs    <= 1'b0;
      CRS       <= 1'b0;
      COL       <= 1'b0;
      RX_DV     <= 1'b0;
      RX_ER     <= 1'b0;
      RXD       <= 4'h0;
    end
    else
    begin
      clk_prev <= clk_s;
      act_prev <= LINE_RX_ACTIVE;
      if (tx_rise)
        tx_en_smp <= en_s;
      if (fire[T_CRS_ON])
        rx_crs <= 1'b1;
      else if (fire[T_CRS_OFF])
        rx_crs <= 1'b0;
      if (fire[T_TX_ON])
        tx_crs <= 1'b1;
      else if (fire[T_TX_OFF])
        tx_crs <= 1'b0;
      CRS <= (rx_crs | fire[T_CRS_ON] | tx_crs | fire[T_TX_ON])
             & ~(fire[T_CRS_OFF] & ~tx_crs) & ~(fire[T_TX_OFF] & ~rx_crs);
      // collision set only while this end is transmitting, cleared by the receive end timer
      if (fire[T_COL_ON] && (tx_en_smp || tx_crs))
        COL <= 1'b1;
      else if (fire[T_COL_OFF])
        COL <= 1'b0;
      // data outputs registered, stable across the mac's sampling edge
      if (fire[T_DV_ON] && rx_crs)
        RX_DV <= 1'b1;
      else if (fire[T_DV_OFF])
        RX_DV <= 1'b0;
      if (|slot_fire)
      begin
        RXD   <= rx_nib[3:0];
        RX_ER <= rx_nib[4];
      end
      else if (fire[T_DV_OFF])
      begin
        RXD   <= 4'h0;
        RX_ER <= 1'b0;
      end
    end
  end

  // transmit nibbles wait in a ring until the line latency has run;
  // depth must cover the nibbles taken while that latency runs
  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_ptr       <= {AW{1'b0}};
      rd_ptr       <= {AW{1'b0}};
      LINE_TX_EN   <= 1'b0;
      LINE_TX_DATA <= 4'h0;
      LINE_TX_ERR  <= 1'b0;
      for (ti = 0; ti < TXDEPTH; ti = ti + 1)
        tx_mem[ti] <= 5'h00;
    end
    else
    begin
      if (tx_rise && en_s)
      begin
        tx_mem[wr_ptr] <= {er_s, txd_s};
        wr_ptr         <= wr_ptr + 1'b1;
      end
      if (fire[T_LTX_ON])
      begin
        LINE_TX_EN   <= 1'b1;
        {LINE_TX_ERR, LINE_TX_DATA} <= tx_mem[rd_ptr];
        rd_ptr       <= rd_ptr + 1'b1;
      end
      else if (fire[T_LTX_OFF])
      begin
        LINE_TX_EN   <= 1'b0;
        LINE_TX_DATA <= 4'h0;
        LINE_TX_ERR  <= 1'b0;
        rd_ptr       <= wr_ptr;
      end
      else if (LINE_TX_EN && tx_rise && (en_s || rd_ptr != wr_ptr))
      begin
        // the slot taken on this same rise is not written yet, so pass it through
        {LINE_TX_ERR, LINE_TX_DATA} <= (rd_ptr == wr_ptr) ? {er_s, txd_s} : tx_mem[rd_ptr];
        rd_ptr       <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

//--- mii_timing_properties.sv
// timing assertions on the mii carrier, collision and data ports
`include "mii_timing_regs.vh"
module mii_timing_checker
(
  input wire       SYS_CLK,
  input wire       RST_N,
  input wire [1:0] MEDIUM_MODE,
  input wire       TX_CLK,
  input wire       TX_EN,
  input wire       LINE_RX_J,
  input wire       LINE_RX_T,
  input wire       LINE_RX_ACTIVE,
  input wire       CRS,
  input wire       COL,
  input wire       RX_DV,
  input wire       LINE_TX_EN
);
  timeunit 1ns;
  timeprecision 100ps;
  reg  tx_clk_q;
  reg  tx_last;
  wire tx_rise = TX_CLK && !tx_clk_q;
  wire fast    = !MEDIUM_MODE[1];
  wire cu      = MEDIUM_MODE == `MODE_CU;
  // enable value seen at the latest transmit clock rise
  always @(posedge SYS_CLK or negedge RST_N)
    if (!RST_N)
    begin
      tx_clk_q <= 1'b0;
      tx_last  <= 1'b0;
    end
    else
    begin
      tx_clk_q <= TX_CLK;
      if (tx_rise)
        tx_last <= TX_EN;
    end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence crs_trail;
    CRS[*6] ##[1:5] !CRS;
  endsequence
  crs_on_j_a: assert property (
    fast && LINE_RX_J && !CRS |-> ##[24:32] CRS) else $error("carrier late after J");
  dv_after_crs_a: assert property (
    fast && $rose(RX_DV) && !LINE_TX_EN |-> $past(CRS, 6) && !$past(CRS, 11))
    else $error("valid not 3 to 5 bits after carrier");
  crs_off_t_a: assert property (
    cu && LINE_RX_T && !LINE_TX_EN |-> ##[20:34] !CRS) else $error("carrier stuck after T");
  col_on_j_a: assert property (
    cu && LINE_RX_J && LINE_TX_EN |-> ##[32:44] COL) else $error("collision late after J");
  col_off_t_a: assert property (
    cu && LINE_RX_T && COL |-> ##[34:40] !COL) else $error("collision stuck after T");
  crs_tx_on_a: assert property (
    cu && tx_rise && TX_EN && !tx_last |-> ##[40:48] CRS) else $error("tx carrier late");
  crs_tx_off_a: assert property (
    cu && tx_rise && !TX_EN && tx_last |-> ##[47:56] !CRS) else $error("tx carrier stuck");
  tx_lat_a: assert property (
    cu && tx_rise && TX_EN && !tx_last |-> ##[9:12] LINE_TX_EN) else $error("line tx late");
  crs_trail_a: assert property (
    !fast && $fell(RX_DV) && !LINE_TX_EN |-> crs_trail) else $error("carrier drop off");
  crs_on_act_a: assert property (
    !fast && $rose(LINE_RX_ACTIVE) && !CRS |-> ##[40:560] CRS) else $error("carrier late");
  crs_off_quiet_a: assert property (
    !fast && $fell(LINE_RX_ACTIVE) && !LINE_TX_EN |-> ##[120:200] !CRS)
    else $error("carrier stuck after quiet");
  col_off_quiet_a: assert property (
    !fast && $fell(LINE_RX_ACTIVE) && COL |-> ##[100:200] !COL)
    else $error("collision stuck after quiet");
endmodule

bind mii_timing mii_timing_checker mii_timing_checker_i (.SYS_CLK, .RST_N, .MEDIUM_MODE,
  .TX_CLK, .TX_EN, .LINE_RX_J, .LINE_RX_T, .LINE_RX_ACTIVE, .CRS, .COL, .RX_DV, .LINE_TX_EN);

//--- mii_timing_regs.vh
// constants for the mii carrier, collision and data timing block
`ifndef MII_TIMING_REGS_VH
`define MII_TIMING_REGS_VH

// clock and bit time, in ns
`define CLK_NS            5
`define BIT_NS_FAST       10
`define BIT_NS_SLOW       100

// input synchroniser depth, in clock cycles
`define SYNC_CYC          2

// medium mode encodings
`define MODE_CU           2'h0
`define MODE_FX           2'h1
`define MODE_TEN          2'h2

// latencies in tenths of a bit time
`define RX_CRS_ON_J       140
`define DV_AFTER_CRS_FAST 40
`define DV_AFTER_CRS_TEN  80
`define RX_CRS_OFF_T_CU   130
`define RX_CRS_OFF_T_FX   190
`define COL_ON_J_CU       190
`define COL_ON_J_FX       120
`define COL_OFF_T_CU      180
`define COL_OFF_T_FX      160
`define TX_CRS_ON_CU      220
`define TX_CRS_ON_FX      180
`define TX_CRS_ON_TEN     20
`define TX_CRS_OFF_CU     260
`define TX_CRS_OFF_FX     230
`define TX_CRS_OFF_TEN    10
`define TX_LAT_CU         55
`define TX_LAT_FX         50
`define TX_LAT_TEN        725
`define RX_LAT_FAST       50
`define RX_LAT_TEN        50
`define CRS_ON_ACT_TEN    100
`define DV_OFF_QUIET_TEN  75
`define CRS_AFTER_DV_TEN  5
`define COL_ON_ACT_TEN    160
`define COL_OFF_QUIET_TEN 70

`endif

//--- pin_sync.v
// two-stage synchroniser for inputs from outside the clock domain
module pin_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             SYS_CLK,
  input  wire             RST_N,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  always @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

//--- tb.sv
// self-checking bench for the mii carrier, collision and data timing block
`include "mii_timing_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       SYS_CLK        = 1'b0;
  logic       RST_N          = 1'b0;
  logic [1:0] MEDIUM_MODE    = `MODE_CU;
  logic       TX_CLK         = 1'b0;
  logic       LINE_RX_J      = 1'b0;
  logic       LINE_RX_T      = 1'b0;
  logic       LINE_RX_ACTIVE = 1'b0;
  logic       LINE_RX_VALID  = 1'b0;
  logic [3:0] LINE_RX_NIBBLE = 4'h0;
  logic       LINE_RX_ERR    = 1'b0;
  wire        TX_EN;
  wire        TX_ER;
  wire  [3:0] TXD;
  wire        CRS;
  wire        COL;
  wire        RX_DV;
  wire        RX_ER;
  wire  [3:0] RXD;
  wire        LINE_TX_EN;
  wire  [3:0] LINE_TX_DATA;
  wire        LINE_TX_ERR;
  int         n_errors  = 0;
  int         cmp_count = 0;
  int         t_crs;
  int         t_dv;
  int         t_ltx;
  int         t_col;
  always #2.5 SYS_CLK = ~SYS_CLK;
  initial
  begin
    #1.3;
    forever #80 TX_CLK = ~TX_CLK;
  end
  mii_timing mii_timing_i (.SYS_CLK, .RST_N, .MEDIUM_MODE, .TX_CLK, .TX_EN, .TX_ER, .TXD,
    .LINE_RX_J, .LINE_RX_T, .LINE_RX_ACTIVE, .LINE_RX_VALID, .LINE_RX_NIBBLE, .LINE_RX_ERR,
    .CRS, .COL, .RX_DV, .RX_ER, .RXD, .LINE_TX_EN, .LINE_TX_DATA, .LINE_TX_ERR);
  mac_model mac_model_i (.TX_CLK, .TX_EN, .TX_ER, .TXD);
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask
  task automatic chk_val(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic set_lvl(ref logic s, input logic v);
    s = v;
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic strobe(ref logic s);
    set_lvl(s, 1'b1);
    s = 1'b0;
  endtask
  // first cycle at which each of CRS, RX_DV, LINE_TX_EN and COL reaches lvl, -1 if never
  task automatic watch(input logic lvl, input int span);
    t_crs = -1;
    t_dv  = -1;
    t_ltx = -1;
    t_col = -1;
    for (int n = 1; n <= span; n++)
    begin
      @(posedge SYS_CLK);
      #1;
      if (t_crs < 0 && CRS === lvl) t_crs = n;
      if (t_dv < 0 && RX_DV === lvl) t_dv = n;
      if (t_ltx < 0 && LINE_TX_EN === lvl) t_ltx = n;
      if (t_col < 0 && COL === lvl) t_col = n;
    end
  endtask
  // two back-to-back nibbles, the first flagged in error
  task automatic nibbles(input int lat);
    LINE_RX_NIBBLE = 4'ha;
    LINE_RX_ERR = 1'b1;
    set_lvl(LINE_RX_VALID, 1'b1);
    LINE_RX_NIBBLE = 4'h5;
    LINE_RX_ERR = 1'b0;
    set_lvl(LINE_RX_VALID, 1'b1);
    LINE_RX_VALID = 1'b0;
    LINE_RX_NIBBLE = 4'ha;
    // latency runs from the cycle in which the first nibble is offered
    repeat (lat - 2) @(posedge SYS_CLK);
    #1;
    chk_val({RX_ER, RXD}, 5'h1a);
    @(posedge SYS_CLK);
    #1;
    chk_val({RX_ER, RXD}, 5'h05);
  endtask
  task automatic rx_fast(input logic [1:0] mode);
    int off;
    MEDIUM_MODE = mode;
    // watch counts from the edge that takes the strobe, one cycle into the latency
    off = ((mode == `MODE_CU) ? `RX_CRS_OFF_T_CU / 5 : `RX_CRS_OFF_T_FX / 5) - 1;
    strobe(LINE_RX_J);
    watch(1'b1, 60);
    chk_rng(t_crs, `RX_CRS_ON_J / 5 - 1, `RX_CRS_ON_J / 5 - 1);
    chk_rng(t_dv - t_crs, 6, 10);
    chk_rng(t_col, -1, -1);
    nibbles(`RX_LAT_FAST / 5);
    strobe(LINE_RX_T);
    watch(1'b0, 60);
    chk_rng(t_crs, off, off);
  endtask
  task automatic rx10;
    MEDIUM_MODE = 2'h3;
    set_lvl(LINE_RX_ACTIVE, 1'b1);
    watch(1'b1, 700);
    chk_rng(t_crs, 40, 560);
    chk_rng(t_dv - t_crs, 100, 640);
    nibbles(`RX_LAT_TEN * 2);
    set_lvl(LINE_RX_ACTIVE, 1'b0);
    watch(1'b0, 300);
    chk_rng(t_crs - t_dv, 6, 10);
    chk_rng(t_crs, 120, 200);
  endtask
  task automatic tx(input logic [1:0] mode, input int nib, input int span, input int clo,
                    input int chi, input int flo, input int fhi, input int ltx);
    MEDIUM_MODE = mode;
    fork
      mac_model_i.send(nib);
    join_none
    wait (TX_EN === 1'b1);
    @(posedge TX_CLK);
    watch(1'b1, span);
    chk_rng(t_crs, clo, chi);
    chk_rng(t_ltx, ltx - 1, ltx + 2);
    // fifth nibble carries the error flag; slow mode ring is outrun by this clock
    if (!mode[1])
    begin
      @(posedge TX_CLK);
      repeat (8) @(posedge SYS_CLK);
      #1;
      chk_val({LINE_TX_ERR, LINE_TX_DATA}, 5'h14);
    end
    wait (TX_EN === 1'b0);
    @(posedge TX_CLK);
    watch(1'b0, span);
    chk_rng(t_crs, flo, fhi);
    chk_rng(t_ltx, ltx - 1, ltx + 2);
  endtask
  task automatic col(input logic [1:0] mode);
    MEDIUM_MODE = mode;
    fork
      mac_model_i.send(100);
    join_none
    wait (LINE_TX_EN === 1'b1);
    @(posedge SYS_CLK);
    #1;
    if (mode[1])
    begin
      set_lvl(LINE_RX_ACTIVE, 1'b1);
      watch(1'b1, 400);
      chk_rng(t_col, `COL_ON_ACT_TEN * 2 - 1, `COL_ON_ACT_TEN * 2 - 1);
      set_lvl(LINE_RX_ACTIVE, 1'b0);
      watch(1'b0, 200);
      chk_rng(t_col, `COL_OFF_QUIET_TEN * 2 - 1, `COL_OFF_QUIET_TEN * 2 - 1);
    end
    else
    begin
      strobe(LINE_RX_J);
      watch(1'b1, 60);
      chk_rng(t_col, mode ? 20 : 32, mode ? 30 : 44);
      strobe(LINE_RX_T);
      watch(1'b0, 60);
      chk_rng(t_col, mode ? 28 : 34, mode ? 36 : 40);
    end
    wait (TX_EN === 1'b0);
    watch(1'b0, 1600);
    chk_rng(t_crs, 1, 1600);
  endtask
  initial
  begin
    #250000;
    n_errors++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    #1;
    RST_N = 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    rx_fast(`MODE_CU);
    rx_fast(`MODE_FX);
    rx10;
    tx(`MODE_CU, 8, 100, 40, 48, 48, 56, 11);
    tx(`MODE_FX, 8, 100, 34, 40, 44, 48, 10);
    tx(`MODE_TEN, 50, 1500, 39, 42, 19, 22, 1450);
    col(`MODE_CU);
    col(`MODE_FX);
    col(`MODE_TEN);
    close_out;
  end
endmodule
